// ---- rfcb_pkg.sv ----
// rfcb_pkg: map, reset values, field layouts and timing of the fault/config bank
// assumes a 250 MHz core clock and commands delivered already deframed
package rfcb_pkg;
    // command codes of the bank
    localparam logic [7:0] OFS_SLEW = 8'h27;
    localparam logic [7:0] OFS_DROOP = 8'h28;
    localparam logic [7:0] OFS_FREQ = 8'h33;
    localparam logic [7:0] OFS_ILV = 8'h37;
    localparam logic [7:0] OFS_CS_GAIN = 8'h38;
    localparam logic [7:0] OFS_CS_OFS = 8'h39;
    localparam logic [7:0] OFS_OV_FLT = 8'h40;
    localparam logic [7:0] OFS_OV_ACT = 8'h41;
    localparam logic [7:0] OFS_OV_WRN = 8'h42;
    localparam logic [7:0] OFS_UV_WRN = 8'h43;
    localparam logic [7:0] OFS_UV_FLT = 8'h44;
    localparam logic [7:0] OFS_UV_ACT = 8'h45;
    localparam logic [7:0] OFS_OC_AVG = 8'h46;
    localparam logic [7:0] OFS_UC_AVG = 8'h4B;
    localparam logic [7:0] OFS_CLEAR = 8'h03;
    localparam int NREG = 14;
    // storage slots, in map order
    localparam logic [3:0] IX_SLEW = 4'h0;
    localparam logic [3:0] IX_DROOP = 4'h1;
    localparam logic [3:0] IX_FREQ = 4'h2;
    localparam logic [3:0] IX_ILV = 4'h3;
    localparam logic [3:0] IX_CS_GAIN = 4'h4;
    localparam logic [3:0] IX_CS_OFS = 4'h5;
    localparam logic [3:0] IX_OV_FLT = 4'h6;
    localparam logic [3:0] IX_OV_ACT = 4'h7;
    localparam logic [3:0] IX_OV_WRN = 4'h8;
    localparam logic [3:0] IX_UV_WRN = 4'h9;
    localparam logic [3:0] IX_UV_FLT = 4'hA;
    localparam logic [3:0] IX_UV_ACT = 4'hB;
    localparam logic [3:0] IX_OC_AVG = 4'hC;
    localparam logic [3:0] IX_UC_AVG = 4'hD;
    // reset values; strap-derived slots hold zero until the strap load
    localparam logic [15:0] RST_VAL [NREG] = '{16'hBA00, 16'h0000, 16'h0000, 16'h0000,
        16'hB380, 16'h0000, 16'h0000, 16'h0080, 16'h0000, 16'h0000, 16'h0000,
        16'h0080, 16'hDBC0, 16'hDC3F};
    // fault action byte layout
    localparam logic [1:0] ACT_RSVD = 2'b10;
    localparam int ACT_RETRY_HI = 5;
    localparam int ACT_RETRY_LO = 3;
    localparam logic [2:0] ACT_RETRY_ALWAYS = 3'b111;
    // placement word layout
    localparam int ILV_GRP_LO = 8;
    localparam int ILV_CNT_LO = 4;
    localparam int ILV_POS_LO = 0;
    // strap multiples of output voltage, in percent
    localparam int PCT_OV_FLT = 115;
    localparam int PCT_OV_WRN = 85;
    localparam int PCT_UV_WRN = 85;
    localparam int PCT_UV_FLT = 85;
    // limits and scaling
    localparam logic [15:0] SLEW_FAST = 16'h7BFF;
    localparam int SLEW_MAX_MVMS = 4000;
    localparam int DROOP_MAX_MVA = 40;
    localparam int FREQ_MIN_KHZ = 300;
    localparam int UV_PER_LSB = 122;
    localparam int CLK_MHZ = 250;
    localparam int SLEW_ACC_STEP = UV_PER_LSB * CLK_MHZ;
    localparam int RETRY_UNIT_MS = 35;
    localparam int RETRY_UNIT_CYC = RETRY_UNIT_MS * CLK_MHZ * 1000;
    localparam int PEAK_MARGIN_A = 8;
    // one command from the serial front end
    typedef struct packed {
        logic write;
        logic [7:0] code;
        logic [15:0] wdata;
    } rfcb_cmd_s;
    // protection sequencing
    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_LATCHED, ST_RETRY} rfcb_state_e;
endpackage : rfcb_pkg

// ---- rfcb_bank.sv ----
// rfcb_bank: configuration and protection bank of a step-down regulator
// assumes deframed commands, same-clock measurement words and a pin enable
`timescale 1ns/1ns
module rfcb_bank #(
    parameter int unsigned RETRY_UNIT = rfcb_pkg::RETRY_UNIT_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire rfcb_pkg::rfcb_cmd_s i_cmd,
    input wire logic i_enable_pin,
    input wire logic [15:0] i_strap_vout,
    input wire logic [15:0] i_strap_freq,
    input wire logic [15:0] i_strap_ilv,
    input wire logic [15:0] i_target_vout,
    input wire logic [15:0] i_vout_meas,
    input wire logic signed [15:0] i_current_sense_input,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    output logic o_cmd_err,
    output logic o_output_en,
    output logic [15:0] o_vout_set,
    output logic o_pgood,
    output logic o_alert_line_n,
    output logic [3:0] o_fault_flags,
    output logic [15:0] o_freq_khz,
    output logic [3:0] o_group_id,
    output logic [4:0] o_group_size,
    output logic [3:0] o_group_pos,
    output logic signed [15:0] o_iout_ma,
    output logic signed [15:0] o_peak_limit_a,
    output logic signed [15:0] o_valley_limit_a
);
    import rfcb_pkg::*;

    // linear-11 word times a scale, as a signed integer
    function automatic logic signed [31:0] rfcb_l11(input logic [15:0] w, input int sc);
        logic signed [4:0] ex;
        logic signed [31:0] pr;
        ex = w[15:11];
        pr = 32'(signed'(w[10:0])) * sc;
        if (ex >= 0) begin
            rfcb_l11 = pr <<< ex;
        end else begin
            rfcb_l11 = pr >>> (-ex);
        end
    endfunction : rfcb_l11

    // command code to slot, top bit marks a hit
    function automatic logic [4:0] rfcb_slot(input logic [7:0] c);
        case (c)
            OFS_SLEW: rfcb_slot = {1'b1, IX_SLEW};
            OFS_DROOP: rfcb_slot = {1'b1, IX_DROOP};
            OFS_FREQ: rfcb_slot = {1'b1, IX_FREQ};
            OFS_ILV: rfcb_slot = {1'b1, IX_ILV};
            OFS_CS_GAIN: rfcb_slot = {1'b1, IX_CS_GAIN};
            OFS_CS_OFS: rfcb_slot = {1'b1, IX_CS_OFS};
            OFS_OV_FLT: rfcb_slot = {1'b1, IX_OV_FLT};
            OFS_OV_ACT: rfcb_slot = {1'b1, IX_OV_ACT};
            OFS_OV_WRN: rfcb_slot = {1'b1, IX_OV_WRN};
            OFS_UV_WRN: rfcb_slot = {1'b1, IX_UV_WRN};
            OFS_UV_FLT: rfcb_slot = {1'b1, IX_UV_FLT};
            OFS_UV_ACT: rfcb_slot = {1'b1, IX_UV_ACT};
            OFS_OC_AVG: rfcb_slot = {1'b1, IX_OC_AVG};
            OFS_UC_AVG: rfcb_slot = {1'b1, IX_UC_AVG};
            default: rfcb_slot = 5'h00;
        endcase
    endfunction : rfcb_slot

    // strap share of output voltage, unsigned fixed-point
    function automatic logic [15:0] rfcb_pct(input logic [15:0] v, input int pct);
        logic [31:0] p;
        p = 32'(v) * 32'(pct) / 32'd100;
        rfcb_pct = p[15:0];
    endfunction : rfcb_pct

    logic [15:0] regs_reg [NREG];
    logic strap_done_reg;
    logic [2:0] en_sync_reg;
    logic en_reg;
    rfcb_state_e state_reg;
    logic [31:0] retry_cnt_reg;
    logic [31:0] slew_acc_reg;
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic [4:0] slot;
    logic wr_hit;
    logic clr;
    logic ov_now;
    logic uv_now;
    logic oc_now;
    logic uc_now;
    logic ramping;
    logic fast;
    logic [31:0] rate;
    logic [7:0] act;
    logic signed [31:0] iout_ma;
    logic signed [31:0] droop_lsb;
    logic signed [31:0] gain_uohm;
    logic signed [31:0] ofs_ma;
    logic signed [31:0] freq;

    assign slot = rfcb_slot(i_cmd.code);
    assign wr_hit = i_cmd_valid & i_cmd.write & slot[4];
    assign clr = i_cmd_valid & i_cmd.write & (i_cmd.code == OFS_CLEAR);

    // enable pin: three stages, change taken when stages two and three agree
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            en_sync_reg <= 3'h0;
            en_reg <= 1'b0;
        end else begin
            en_sync_reg <= {en_sync_reg[1:0], i_enable_pin};
            if (en_sync_reg[1] == en_sync_reg[2]) begin
                en_reg <= en_sync_reg[2];
            end
        end
    end

    // register store; strap values caught on the first edge after release
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int k = 0; k < NREG; k++) begin
                regs_reg[k] <= RST_VAL[k];
            end
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            regs_reg[IX_FREQ] <= i_strap_freq;
            regs_reg[IX_ILV] <= i_strap_ilv;
            regs_reg[IX_OV_FLT] <= rfcb_pct(i_strap_vout, PCT_OV_FLT);
            regs_reg[IX_OV_WRN] <= rfcb_pct(i_strap_vout, PCT_OV_WRN);
            regs_reg[IX_UV_WRN] <= rfcb_pct(i_strap_vout, PCT_UV_WRN);
            regs_reg[IX_UV_FLT] <= rfcb_pct(i_strap_vout, PCT_UV_FLT);
        end else if (wr_hit) begin
            if (slot[3:0] == IX_OV_ACT || slot[3:0] == IX_UV_ACT) begin
                regs_reg[slot[3:0]] <= {8'h00, ACT_RSVD, i_cmd.wdata[5:0]};
            end else begin
                regs_reg[slot[3:0]] <= i_cmd.wdata;
            end
        end
    end

    // read answer one cycle after the request; unmapped reads zero with error
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
            o_rvalid <= 1'b0;
            o_cmd_err <= 1'b0;
        end else begin
            o_rvalid <= i_cmd_valid & ~i_cmd.write;
            o_rdata <= slot[4] ? regs_reg[slot[3:0]] : 16'h0000;
            o_cmd_err <= i_cmd_valid & ~slot[4] & ~clr;
        end
    end

    // comparisons against the unsigned voltage limits and the signed current limits
    always_comb begin
        ov_now = o_output_en && (i_vout_meas > regs_reg[IX_OV_FLT]);
        uv_now = o_output_en && !ramping && (i_vout_meas < regs_reg[IX_UV_FLT]);
        oc_now = o_output_en && (32'(i_current_sense_input) > 32'(o_peak_limit_a));
        uc_now = o_output_en && (32'(i_current_sense_input) < 32'(o_valley_limit_a));
        act = ov_now ? regs_reg[IX_OV_ACT][7:0] : regs_reg[IX_UV_ACT][7:0];
    end

    // fault flags: a present fault always wins over a clear
    assign flags_next = (flags_reg & {4{~clr}}) | {uc_now, oc_now, uv_now, ov_now};
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            flags_reg <= 4'h0;
            o_fault_flags <= 4'h0;
            o_alert_line_n <= 1'b1;
        end else begin
            flags_reg <= flags_next;
            o_fault_flags <= flags_next;
            o_alert_line_n <= ~|flags_next;
        end
    end

    // protection sequencer; only the enable pin restarts a latched output
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg <= ST_OFF;
            retry_cnt_reg <= 32'h0;
            o_output_en <= 1'b0;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    if (en_reg) begin
                        state_reg <= ST_RUN;
                        o_output_en <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!en_reg) begin
                        state_reg <= ST_OFF;
                        o_output_en <= 1'b0;
                    end else if (ov_now || uv_now) begin
                        o_output_en <= 1'b0;
                        if (act[ACT_RETRY_HI:ACT_RETRY_LO] == ACT_RETRY_ALWAYS) begin
                            state_reg <= ST_RETRY;
                            retry_cnt_reg <= 32'((act[2:0] + 4'd1) * RETRY_UNIT - 1);
                        end else begin
                            state_reg <= ST_LATCHED;
                        end
                    end
                end
                ST_LATCHED: begin
                    if (!en_reg) begin
                        state_reg <= ST_OFF;
                    end
                end
                ST_RETRY: begin
                    if (!en_reg) begin
                        state_reg <= ST_OFF;
                    end else if (retry_cnt_reg == 32'h0) begin
                        state_reg <= ST_RUN;
                        o_output_en <= 1'b1;
                    end else begin
                        retry_cnt_reg <= retry_cnt_reg - 32'd1;
                    end
                end
                default: begin
                    state_reg <= ST_OFF;
                    o_output_en <= 1'b0;
                end
            endcase
        end
    end

    // slew setpoint toward target, one lsb per accumulator overflow
    assign fast = (regs_reg[IX_SLEW] == SLEW_FAST);
    assign ramping = (o_vout_set != i_target_vout);
    always_comb begin
        rate = 32'(rfcb_l11(regs_reg[IX_SLEW], 1000));
        if (rfcb_l11(regs_reg[IX_SLEW], 1000) > SLEW_MAX_MVMS) begin
            rate = 32'(SLEW_MAX_MVMS);
        end else if (rfcb_l11(regs_reg[IX_SLEW], 1000) < 1) begin
            rate = 32'd1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_vout_set <= 16'h0000;
            slew_acc_reg <= 32'h0;
        end else if (!o_output_en) begin
            o_vout_set <= 16'h0000;
            slew_acc_reg <= 32'h0;
        end else if (fast) begin
            o_vout_set <= i_target_vout;
        end else if (!ramping) begin
            slew_acc_reg <= 32'h0;
        end else if (slew_acc_reg + rate >= 32'(SLEW_ACC_STEP)) begin
            slew_acc_reg <= slew_acc_reg + rate - 32'(SLEW_ACC_STEP);
            if (o_vout_set < i_target_vout) begin
                o_vout_set <= o_vout_set + 16'd1;
            end else begin
                o_vout_set <= o_vout_set - 16'd1;
            end
        end else begin
            slew_acc_reg <= slew_acc_reg + rate;
        end
    end

    // power good from the two warning thresholds
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_pgood <= 1'b0;
        end else begin
            o_pgood <= o_output_en && !(i_vout_meas > regs_reg[IX_OV_WRN])
                && !(i_vout_meas < regs_reg[IX_UV_WRN]);
        end
    end

    // current reading, droop and derived cycle limits
    always_comb begin
        gain_uohm = rfcb_l11(regs_reg[IX_CS_GAIN], 1000);
        ofs_ma = rfcb_l11(regs_reg[IX_CS_OFS], 1000);
        iout_ma = (gain_uohm > 0) ? (32'(i_current_sense_input) * 1000) / gain_uohm : 32'sd0;
        iout_ma = iout_ma + ofs_ma;
        droop_lsb = rfcb_l11(regs_reg[IX_DROOP], 1);
        if (droop_lsb > DROOP_MAX_MVA) begin
            droop_lsb = 32'(DROOP_MAX_MVA);
        end else if (droop_lsb < 0) begin
            droop_lsb = 32'sd0;
        end
        droop_lsb = (droop_lsb * iout_ma * 8389) >>> 20;
        freq = rfcb_l11(regs_reg[IX_FREQ], 1);
        if (freq < FREQ_MIN_KHZ) begin
            freq = 32'(FREQ_MIN_KHZ);
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_iout_ma <= 16'sh0000;
            o_peak_limit_a <= 16'sh0000;
            o_valley_limit_a <= 16'sh0000;
            o_freq_khz <= 16'h0000;
        end else begin
            o_iout_ma <= iout_ma[15:0];
            o_peak_limit_a <= 16'(rfcb_l11(regs_reg[IX_OC_AVG], 1) + PEAK_MARGIN_A);
            o_valley_limit_a <= 16'(rfcb_l11(regs_reg[IX_UC_AVG], 1) - PEAK_MARGIN_A);
            o_freq_khz <= freq[15:0];
        end
    end

    // phase placement within an phase_group_placement group
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_group_id <= 4'h0;
            o_group_size <= 5'h10;
            o_group_pos <= 4'h0;
        end else begin
            o_group_id <= regs_reg[IX_ILV][ILV_GRP_LO +: 4];
            o_group_pos <= regs_reg[IX_ILV][ILV_POS_LO +: 4];
            if (regs_reg[IX_ILV][ILV_CNT_LO +: 4] == 4'h0) begin
                o_group_size <= 5'h10;
            end else begin
                o_group_size <= {1'b0, regs_reg[IX_ILV][ILV_CNT_LO +: 4]};
            end
        end
    end

    AST_ACT_RSVD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        regs_reg[IX_OV_ACT][7:6] == 2'b10 && regs_reg[IX_UV_ACT][7:6] == 2'b10)
        else $error("action byte reserved bits not 10");
    AST_OV_SHUTS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ov_now && en_reg |=> !o_output_en ##1 !o_output_en)
        else $error("overvoltage did not shut the output");
    AST_LATCH_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_reg == ST_LATCHED && en_reg && clr |=> state_reg == ST_LATCHED && !o_output_en)
        else $error("latched output restarted");
    AST_RETRY_END: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        state_reg == ST_RETRY && retry_cnt_reg == 32'h0 && en_reg |=> o_output_en)
        else $error("retry did not restart on time");
    AST_SLEW_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_output_en && $past(o_output_en) && !fast && $stable(i_target_vout)
        |-> (o_vout_set - $past(o_vout_set) <= 16'd1) || ($past(o_vout_set) - o_vout_set <= 16'd1))
        else $error("setpoint moved faster than one step");
    AST_FAST: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_output_en && fast && en_reg && !ov_now && !uv_now ##1 o_output_en && fast
        |-> o_vout_set == $past(i_target_vout))
        else $error("fast transition not immediate");
    AST_PG_OV: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_vout_meas > regs_reg[IX_OV_WRN] |=> !o_pgood)
        else $error("power good high above warning");
    AST_PG_UV: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_vout_meas < regs_reg[IX_UV_WRN] |=> !o_pgood)
        else $error("power good high below warning");
    AST_UV_MASK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!o_output_en || ramping) && !o_fault_flags[1] |=> !o_fault_flags[1])
        else $error("undervoltage flagged while masked");
    AST_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        clr |=> o_fault_flags == {$past(uc_now), $past(oc_now), $past(uv_now), $past(ov_now)}
            && o_alert_line_n == !(|o_fault_flags))
        else $error("flags after clear differ from present faults");
    AST_GRP16: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        strap_done_reg && regs_reg[IX_ILV][7:4] == 4'h0 |=> o_group_size == 5'h10)
        else $error("zero rail count not sixteen");
endmodule : rfcb_bank

// ---- rfcb_host.sv ----
// rfcb_host: host controller model issuing deframed bank commands
// assumes answers are registered on the same edge that takes a command
`timescale 1ns/1ns
module rfcb_host
    import rfcb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_output_en,
    input wire logic [15:0] i_rdata,
    output logic o_cmd_valid,
    output rfcb_pkg::rfcb_cmd_s o_cmd
);
    // bus idle at time zero
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd = '0;
    end
    // one command, raised after an edge and held over the taking edge; a frequency write while the output is enabled is dropped
    task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
        if (w && c == OFS_FREQ && i_output_en) begin
            return;
        end
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b1;
        o_cmd = '{write: w, code: c, wdata: d};
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd.wdata = ~d; // released word never shows stale data
    endtask : send
    // read: answer sampled once the taking edge has landed
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        send(1'b0, c, 16'h0000);
        d = i_rdata;
    endtask : rd
endmodule : rfcb_host

// ---- rfcb_bank_bench.sv ----
// rfcb_bank_bench: self-checking bench of the fault/config bank
// assumes rfcb_host drives commands; retry unit shortened to RU cycles
`timescale 1ns/1ns
module rfcb_bank_bench;
    import rfcb_pkg::*;
    localparam int RU = 10;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic pin = 1'b0;
    logic [15:0] meas = 16'h2000;
    logic signed [15:0] current_sense_input = 16'sh0000;
    logic [15:0] iout, pk, vl;
    logic cmd_valid, rvalid, cmd_err, out_en, pgood, alert_n;
    rfcb_cmd_s cmd;
    logic [15:0] rdata, vset, freq;
    logic [3:0] flags, gid, gpos;
    logic [4:0] gsz;
    int fails = 0;
    int compares = 0;
    int cyc;
    // clock, 4 ns period
    always #2 i_clk = ~i_clk;
    rfcb_host rfcb_host_i (.i_clk(i_clk), .i_output_en(out_en), .i_rdata(rdata),
        .o_cmd_valid(cmd_valid), .o_cmd(cmd));
    rfcb_bank #(.RETRY_UNIT(RU)) rfcb_bank_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_enable_pin(pin),
        .i_strap_vout(16'h2000), .i_strap_freq(16'h01F4), .i_strap_ilv(16'h0305),
        .i_target_vout(16'h2000), .i_vout_meas(meas), .i_current_sense_input(current_sense_input),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_cmd_err(cmd_err), .o_output_en(out_en),
        .o_vout_set(vset), .o_pgood(pgood), .o_alert_line_n(alert_n),
        .o_fault_flags(flags), .o_freq_khz(freq), .o_group_id(gid),
        .o_group_size(gsz), .o_group_pos(gpos), .o_iout_ma(iout),
        .o_peak_limit_a(pk), .o_valley_limit_a(vl));
    // counts and reports one comparison
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step
    // read with answer and error pulse judged together
    task automatic rchk(input logic [7:0] c, input logic [15:0] e, input logic er);
        logic [15:0] d;
        rfcb_host_i.rd(c, d);
        chk({14'h0000, rvalid, cmd_err}, {14'h0000, 1'b1, er});
        chk(d, e);
    endtask : rchk
    // bounded wait for the output enable to reach v
    task automatic wait_en(input logic v);
        cyc = 0;
        while (out_en !== v && cyc < 200) begin
            step(1);
            cyc++;
        end
        if (cyc == 200) begin
            fails++;
            $display("BAD t=%0t enable wait timed out", $time);
            conclude();
        end
    endtask : wait_en
    task automatic t_map;
        logic [7:0] c [12] = '{8'h27, 8'h28, 8'h38, 8'h39, 8'h40, 8'h41, 8'h42,
            8'h43, 8'h44, 8'h45, 8'h46, 8'h4B};
        logic [15:0] e [12] = '{16'hBA00, 16'h0000, 16'hB380, 16'h0000, 16'h24CC,
            16'h0080, 16'h1B33, 16'h1B33, 16'h1B33, 16'h0080, 16'hDBC0, 16'hDC3F};
        for (int i = 0; i < 12; i++) begin
            rchk(c[i], e[i], 1'b0);
        end
        rfcb_host_i.send(1'b1, OFS_OV_ACT, 16'h00FF);
        rchk(OFS_OV_ACT, 16'h00BF, 1'b0);
        rchk(8'h50, 16'h0000, 1'b1);
        chk({gid, 3'h0, gsz, gpos}, 16'h3105);
        rfcb_host_i.send(1'b1, OFS_ILV, 16'h0A27);
        step(2);
        chk({gid, 3'h0, gsz, gpos}, 16'hA027);
        rfcb_host_i.send(1'b1, OFS_FREQ, 16'h01F4);
        step(2);
        chk(freq, 16'd500);
        rfcb_host_i.send(1'b1, OFS_FREQ, 16'h0064);
        step(2);
        chk(freq, 16'd300);
    endtask : t_map
    task automatic t_run;
        rfcb_host_i.send(1'b1, OFS_SLEW, SLEW_FAST);
        rfcb_host_i.send(1'b1, OFS_OV_WRN, 16'h2200);
        rfcb_host_i.send(1'b1, OFS_UV_WRN, 16'h1E00);
        rfcb_host_i.send(1'b1, OFS_OV_ACT, 16'h0080);
        pin = 1'b1;
        wait_en(1'b1);
        step(2);
        chk(vset, 16'h2000);
        chk({15'h0000, pgood}, 16'h0001);
        meas = 16'h2300;
        step(3);
        chk({15'h0000, pgood}, 16'h0000);
        meas = 16'h1D00;
        step(3);
        chk({15'h0000, pgood}, 16'h0000);
        meas = 16'h2000;
    endtask : t_run
    task automatic t_latch;
        meas = 16'h2600;
        wait_en(1'b0);
        chk(cyc[15:0], 16'd1);
        chk({11'h000, alert_n, flags}, 16'h0001);
        rfcb_host_i.send(1'b1, OFS_CLEAR, 16'h0000);
        step(1);
        chk({11'h000, alert_n, flags}, 16'h0010);
        meas = 16'h1000;
        rfcb_host_i.send(1'b1, OFS_CLEAR, 16'h0000);
        step(3);
        chk({10'h000, out_en, alert_n, flags}, 16'h0010);
        meas = 16'h2000;
        pin = 1'b0;
        step(6);
        pin = 1'b1;
        wait_en(1'b1);
    endtask : t_latch
    task automatic t_retry;
        rfcb_host_i.send(1'b1, OFS_OV_ACT, 16'h00F9);
        meas = 16'h2600;
        wait_en(1'b0);
        wait_en(1'b1);
        chk({15'h0000, cyc >= 2 * RU - 1 && cyc <= 2 * RU + 2}, 16'h0001);
        wait_en(1'b0);
        chk({15'h0000, cyc <= 2}, 16'h0001);
        meas = 16'h2000;
        pin = 1'b0;
        step(8);
    endtask : t_retry
    // limited slew, current reading, derived limits and a clear under a live fault
    task automatic t_slew;
        rfcb_host_i.send(1'b1, OFS_SLEW, 16'h0008);
        pin = 1'b1;
        wait_en(1'b1);
        step(122);
        chk(vset, 16'h0010);
        current_sense_input = 16'sd100;
        step(2);
        chk(iout, 16'd114);
        chk(pk, 16'd38);
        chk(vl, 16'hFFD9);
        rfcb_host_i.send(1'b1, OFS_CLEAR, 16'h0000);
        step(1);
        chk({11'h000, alert_n, flags}, 16'h0004);
        current_sense_input = 16'sh0000;
        rfcb_host_i.send(1'b1, OFS_CLEAR, 16'h0000);
        step(1);
        chk({10'h000, out_en, alert_n, flags}, 16'h0030);
        pin = 1'b0;
        step(8);
    endtask : t_slew
    task automatic conclude;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    // reset for 4 cycles, then the scenarios in order
    initial begin
        repeat (4) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        step(2);
        t_map();
        t_run();
        t_latch();
        t_retry();
        t_slew();
        conclude();
    end
endmodule : rfcb_bank_bench
